// file: src/or_and_literal_load_exec.sv
// Function
// (RULE1) OR accumulator with file, d=0 to accumulator
// (RULE2) d=1 writes file, accumulator kept
// (RULE3) Literal load copies 8-bit literal to accumulator
// (RULE4) Two literal opcode bits are don't-care
// (RULE5) One cycle, four phases; OR sets zero
`timescale 1ns/1ps
`include "or_ld_defs.svh"
module or_and_literal_load_exec
    import or_ld_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [13:0] instr,
    input wire logic [7:0] file_rdata,
    output logic [6:0] file_raddr,
    output file_wr_s file_wr,
    output logic [7:0] accum,
    output logic zero_flag,
    output logic zero_wr,
    output logic [1:0] phase,
    output logic busy
);
    phase_e ph, next_ph;
    op_e op, next_op;
    logic [13:0] iw, next_iw;
    logic [7:0] opnd, next_opnd;
    logic [7:0] res, next_res;
    logic [7:0] next_accum;
    logic next_zero_flag, next_zero_wr;
    file_wr_s next_file_wr;

    // Every assertion lives in the one instruction clock domain
    default clocking cb_instr @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    function automatic op_e decode(input logic [13:0] w);
        decode = OP_NONE;
        if (w[`IW_TOP_HI:`IW_TOP_LO] == `TOP_ALU &&
            w[`IW_OP_HI:`IW_OP_LO] == `OP_IOR)
            decode = OP_IOR;
        // Low two opcode bits ignored in the literal form
        if (w[`IW_TOP_HI:`IW_TOP_LO] == `TOP_LIT &&
            w[`IW_LIT_HI:`IW_LIT_MID] == `LIT_LOAD_SEL) // see RULE4
            decode = OP_LDL;
    endfunction : decode

    assign file_raddr = iw[`IW_FA_HI:`IW_FA_LO];
    assign phase = ph;
    assign busy = (op != OP_NONE);

    always_comb
    begin
        next_ph = ph;
        next_op = op;
        next_iw = iw;
        next_opnd = opnd;
        next_res = res;
        next_accum = accum;
        next_zero_flag = zero_flag;
        next_zero_wr = 1'b0;
        next_file_wr = '0;
        if (clk_en)
        begin
            // Phase counter advances only on an enabled edge: every instruction is one cycle
            unique case (ph)
                PH_DECODE: // see RULE5
                begin
                    next_iw = instr;
                    next_op = decode(instr);
                    next_ph = PH_READ;
                end
                PH_READ:
                begin
                    if (op == OP_LDL)
                        next_opnd = iw[`IW_K_HI:`IW_K_LO]; // see RULE3
                    else
                        next_opnd = file_rdata;
                    next_ph = PH_PROC;
                end
                PH_PROC:
                begin
                    if (op == OP_IOR)
                        next_res = accum | opnd; // see RULE1
                    else
                        next_res = opnd;
                    next_ph = PH_WRITE;
                end
                PH_WRITE:
                begin
                    if (op == OP_IOR)
                    begin
                        next_zero_flag = (res == 8'h00); // see RULE5
                        next_zero_wr = 1'b1;
                        if (iw[`IW_DEST_BIT])
                        begin
                            next_file_wr.wr = 1'b1; // see RULE2
                            next_file_wr.addr = iw[`IW_FA_HI:`IW_FA_LO];
                            next_file_wr.data = res;
                        end
                        else
                            next_accum = res; // see RULE1
                    end
                    else if (op == OP_LDL)
                        next_accum = res; // see RULE3
                    next_op = OP_NONE;
                    next_ph = PH_DECODE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ph <= PH_DECODE;
            op <= OP_NONE;
            iw <= '0;
            opnd <= '0;
            res <= '0;
            accum <= `ACC_RESET;
            zero_flag <= 1'b0;
            zero_wr <= 1'b0;
            file_wr <= '0;
        end
        else
        begin
            ph <= next_ph;
            op <= next_op;
            iw <= next_iw;
            opnd <= next_opnd;
            res <= next_res;
            accum <= next_accum;
            zero_flag <= next_zero_flag;
            zero_wr <= next_zero_wr;
            file_wr <= next_file_wr;
        end
    end

    // Helper sequences for the phases of one instruction
    sequence s_ior_write;
        ph == PH_WRITE && op == OP_IOR && clk_en;
    endsequence

    sequence s_lit_write;
        ph == PH_WRITE && op == OP_LDL && clk_en;
    endsequence

    sequence s_decode_taken;
        ph == PH_DECODE && clk_en;
    endsequence

    // Read, process and write: only counts when none of them is frozen
    sequence s_rest_of_cycle;
        clk_en [*3];
    endsequence

    sequence s_ior_to_accum;
        s_ior_write and !iw[`IW_DEST_BIT];
    endsequence

    sequence s_ior_to_file;
        s_ior_write and iw[`IW_DEST_BIT];
    endsequence

    sequence s_lit_decoded;
        s_decode_taken ##0 decode(instr) == OP_LDL;
    endsequence

    a_ior_or_result: assert property ( // see RULE1
        ph == PH_PROC && op == OP_IOR && clk_en |=>
        res == ($past(accum) | $past(opnd)))
        else $error("OR of accumulator and operand wrong");

    a_ior_acc_dest: assert property ( // see RULE1
        s_ior_to_accum |=> accum == $past(res))
        else $error("OR result not placed in accumulator");

    a_no_file_wr_d0: assert property ( // see RULE1
        s_ior_to_accum |=> !file_wr.wr)
        else $error("Unexpected file write");

    a_ior_file_dest: assert property ( // see RULE2
        s_ior_to_file |=> file_wr.wr && file_wr.data == $past(res) &&
        $stable(accum))
        else $error("OR result not written to file");

    a_ior_file_addr: assert property ( // see RULE2
        s_ior_to_file |=>
        file_wr.addr == $past(iw[`IW_FA_HI:`IW_FA_LO]))
        else $error("OR result written to wrong file address");

    a_lit_load: assert property ( // see RULE3
        s_lit_decoded ##1 s_rest_of_cycle |=>
        accum == $past(instr[`IW_K_HI:`IW_K_LO], 4))
        else $error("Literal not loaded");

    a_lit_no_file: assert property ( // see RULE3
        s_lit_write |=> !file_wr.wr)
        else $error("Literal load wrote a file register");

    a_noop_quiet: assert property ( // see RULE3
        ph == PH_WRITE && op == OP_NONE && clk_en |=>
        !file_wr.wr && !zero_wr && $stable(accum))
        else $error("Unrecognised word changed state");

    a_lit_dontcare: assert property ( // see RULE4
        s_decode_taken ##0
        instr[`IW_TOP_HI:`IW_LIT_MID] == {`TOP_LIT, `LIT_LOAD_SEL}
        |=> op == OP_LDL)
        else $error("Literal decode depends on don't-care bits");

    a_lit_no_flag: assert property ( // see RULE5
        s_lit_write |=> !zero_wr && $stable(zero_flag))
        else $error("Literal load touched zero flag");

    a_ior_zero: assert property ( // see RULE5
        s_ior_write |=> zero_wr && zero_flag == ($past(res) == 8'h00))
        else $error("Zero flag wrong after OR");

    a_phase_cycle: assert property ( // see RULE5
        s_decode_taken ##1 s_rest_of_cycle |=> ph == PH_DECODE)
        else $error("Instruction did not complete in one cycle");

    a_phase_step: assert property ( // see RULE5
        clk_en |=> ph != $past(ph))
        else $error("Enabled edge did not advance the phase");

    // A frozen edge must leave ph, op, iw, accum and zero_flag and both pulses quiet
    a_freeze_state: assert property ( // see RULE5
        !clk_en |=> $stable(ph) && $stable(op) && $stable(iw) &&
        $stable(accum) && $stable(zero_flag))
        else $error("State moved while the enable was low");

    a_pulse_drop: assert property ( // see RULE5
        !clk_en |=> !zero_wr && !file_wr.wr)
        else $error("Write pulse stood through a frozen edge");
endmodule : or_and_literal_load_exec

// file: src/or_ld_defs.svh
`ifndef OR_LD_DEFS_SVH
`define OR_LD_DEFS_SVH
`define IW_TOP_HI 13
`define IW_TOP_LO 12
`define IW_OP_HI 11
`define IW_OP_LO 8
`define IW_LIT_HI 11
`define IW_LIT_MID 10
`define IW_DEST_BIT 7
`define IW_FA_HI 6
`define IW_FA_LO 0
`define IW_K_HI 7
`define IW_K_LO 0
`define TOP_ALU 2'h0
`define TOP_LIT 2'h3
`define OP_IOR 4'h4
`define LIT_LOAD_SEL 2'h0
`define ACC_RESET 8'h00
`endif

// file: src/or_ld_pkg.sv
`include "or_ld_defs.svh"
package or_ld_pkg;
    typedef enum logic [1:0] {PH_DECODE, PH_READ, PH_PROC, PH_WRITE} phase_e;
    typedef enum logic [1:0] {OP_NONE, OP_IOR, OP_LDL} op_e;
    typedef struct packed {
        logic wr;
        logic [6:0] addr;
        logic [7:0] data;
    } file_wr_s;
endpackage : or_ld_pkg

// file: test/tb.sv
`timescale 1ns/1ps
module tb;
    import or_ld_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic [13:0] instr = 14'h0000;
    logic [7:0] file_rdata = 8'h00;
    logic [6:0] file_raddr;
    file_wr_s file_wr;
    logic [7:0] accum;
    logic zero_flag;
    logic zero_wr;
    logic [1:0] phase;
    logic busy;
    int num_errors = 0;
    int n_tests = 0;

    initial
    begin
        forever #50 ref_clk = ~ref_clk;
    end

    or_and_literal_load_exec or_and_literal_load_exec_i (.ref_clk, .rst_n,
        .clk_en, .instr, .file_rdata, .file_raddr, .file_wr, .accum,
        .zero_flag, .zero_wr, .phase, .busy);

    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Four enabled edges make one instruction; the next word follows at once
    task exec(input logic [13:0] iw, input logic [7:0] rd);
        instr = iw;
        file_rdata = rd;
        repeat (4) @(negedge ref_clk);
    endtask : exec

    task t_or_accum;
        exec(14'h3091, 8'h00);
        exec(14'h0425, 8'h13);
        chk(16'(accum), 16'h0093);
        chk(16'(file_raddr), 16'h0025);
        chk(16'({file_wr.wr, zero_wr, zero_flag}), 16'h0002);
        chk(16'(phase), 16'h0000);
    endtask : t_or_accum

    task t_or_file;
        exec(14'h04FF, 8'h0C);
        chk(16'(file_wr), 16'hFF9F);
        chk(16'(accum), 16'h0093);
        chk(16'(zero_wr), 16'h0001);
    endtask : t_or_file

    task t_literal;
        logic [7:0] k;
        for (int dc = 0; dc < 4; dc++)
        begin
            k = 8'hA5 ^ 8'(dc * 8'h11);
            exec({4'hC, 2'(dc), k}, 8'hFF);
            chk(16'(accum), {8'h00, k});
            chk(16'({file_wr.wr, zero_wr}), 16'h0000);
        end
    endtask : t_literal

    // A zero result sets the flag, and a later literal load leaves it alone
    task t_zero;
        exec(14'h3000, 8'h00);
        exec(14'h0410, 8'h00);
        chk(16'({zero_wr, zero_flag, accum}), 16'h0300);
        exec(14'h305A, 8'h00);
        chk(16'({zero_wr, zero_flag, accum}), 16'h015A);
    endtask : t_zero

    task t_noop;
        exec(14'h0825, 8'h01);
        exec(14'h3477, 8'h01);
        chk(16'({file_wr.wr, zero_wr}), 16'h0000);
        chk(16'({zero_flag, accum}), 16'h015A);
    endtask : t_noop

    // Busy marks a recognised word in flight; phases step once per edge
    task t_busy;
        instr = 14'h3022;
        @(negedge ref_clk);
        chk(16'({busy, phase}), 16'h0005);
        repeat (3) @(negedge ref_clk);
        chk(16'({busy, phase, accum}), 16'h0022);
        instr = 14'h0825;
        @(negedge ref_clk);
        chk(16'({busy, phase}), 16'h0001);
        repeat (3) @(negedge ref_clk);
    endtask : t_busy

    // A low enable holds an instruction mid-way; it then completes normally
    task t_freeze;
        instr = 14'h0433;
        file_rdata = 8'h81;
        @(negedge ref_clk);
        clk_en = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk(16'({phase, file_raddr}), 16'h00B3);
        chk(16'(accum), 16'h0022);
        clk_en = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk(16'({zero_wr, zero_flag, accum}), 16'h02A3);
        clk_en = 1'b0;
        @(negedge ref_clk);
        chk(16'({zero_wr, phase}), 16'h0000);
        clk_en = 1'b1;
    endtask : t_freeze

    // A mid-run reset clears the accumulator and restarts at decode
    task t_reset;
        instr = 14'h0000;
        rst_n = 1'b0;
        @(negedge ref_clk);
        chk(16'({busy, phase, zero_flag, accum}), 16'h0000);
        rst_n = 1'b1;
        exec(14'h04C4, 8'h40);
        chk(16'(file_wr), 16'hC440);
        chk(16'(accum), 16'h0000);
    endtask : t_reset

    task summarize;
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize

    initial
    begin
        #200000;
        num_errors++;
        summarize;
    end

    initial
    begin
        repeat (12) @(negedge ref_clk);
        rst_n = 1'b1;
        t_or_accum;
        t_or_file;
        t_literal;
        t_zero;
        t_noop;
        t_busy;
        t_freeze;
        t_reset;
        summarize;
    end
endmodule : tb
